/* File: hw/fsp_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fsp_bus_if;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr_strobe;
	logic rd_strobe;
	logic io_select;
	logic [fsp_pkg::N_MAIN-1:0] main_sector_select;
	logic [fsp_pkg::N_BOOT-1:0] boot_sector_select;
	logic flash_ready;
	modport dev (
		input addr, wdata, wr_strobe, rd_strobe, io_select,
		input main_sector_select, boot_sector_select,
		output rdata, flash_ready
	);
	modport mcu (
		output addr, wdata, wr_strobe, rd_strobe, io_select,
		output main_sector_select, boot_sector_select,
		input rdata, flash_ready
	);
endinterface
`default_nettype wire

/* File: hw/fsp_flash_dev.sv */
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (RULE1) protection read: three writes, then read
// (RULE2) protection read gives 01h protected, 00h not
// (RULE3) status readable any number of times
// (RULE4) status: poll, toggle, error, window bits
// (RULE5) programming: poll bit is complement, then true
// (RULE6) status valid after fourth or sixth write
// (RULE7) erase: poll bit zero, then array data
// (RULE8) program to protected sector is ignored
// (RULE9) all-protected erase: busy 100 us, no erase
// (RULE10) toggle bit flips on each busy read
// (RULE11) error bit set on failed program or erase
// (RULE12) error bit cleared by reset instruction
// (RULE13) erase window bit low for window period
// (RULE14) erase sets ones; program clears bits only
// (RULE15) controller waits for completion before next op
// (RULE16) data polling compares bit 7, rechecks on error
// (RULE17) toggle check: equal reads mean done
// (RULE18) erase status readable inside erased sector
// (RULE19) controller re-reads programmed byte to verify
// (RULE20) controller stops using a failed sector
// (RULE21) protection registers readable in i/o space
// (RULE22) unlock writes aa@555, 55@aaa, then command
// (RULE23) reset instruction needed after protection read, error
// (RULE24) ready output low while algorithm runs
module fsp_flash_dev #(
	parameter int DEPTH = 4,
	parameter int PROG_CYC = 40,
	parameter int ERASE_CYC = 400
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// microcontroller bus
	fsp_bus_if.dev bus,
	// protection settings and fault injection
	input wire logic [fsp_pkg::N_MAIN-1:0] prot_main,
	input wire logic [fsp_pkg::N_BOOT-1:0] prot_boot,
	input wire logic force_fail
);
	// ==========================================================
	// types and constants
	localparam int SECS = fsp_pkg::N_MAIN + fsp_pkg::N_BOOT;
	localparam int AW = $clog2(DEPTH);
	localparam logic [fsp_pkg::TW-1:0] PROG_T = fsp_pkg::TW'(PROG_CYC);
	localparam logic [fsp_pkg::TW-1:0] ERASE_T = fsp_pkg::TW'(ERASE_CYC);
	localparam logic [fsp_pkg::TW-1:0] WINDOW_T = fsp_pkg::TW'(fsp_pkg::WINDOW_CYC);
	localparam logic [fsp_pkg::TW-1:0] BLANK_T = fsp_pkg::TW'(fsp_pkg::BLANK_CYC);

	typedef enum logic [3:0] {
		S_READ, S_UNL1, S_UNL2, S_PROG_DATA, S_ER_UNL0, S_ER_UNL1, S_ER_UNL2,
		S_PROT, S_WINDOW, S_PROG_BUSY, S_ERASE_BUSY, S_BLANK, S_ERROR
	} fsp_dev_st_t;

	typedef struct packed {
		fsp_dev_st_t st;
		logic [fsp_pkg::TW-1:0] timer;
		logic [SECS-1:0] erase_mask;
		logic [3:0] psec;
		logic [AW-1:0] paddr;
		logic [7:0] pdata;
		logic is_prog;
		logic toggle;
		logic error;
		logic [7:0] rdata;
		logic ready;
		logic [SECS*DEPTH*8-1:0] mem;
	} fsp_dev_q_t;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PROG_CYC < 1 || PROG_CYC > 4095 ||
		ERASE_CYC < 1 || ERASE_CYC > 4095) begin : g_bad_param
		$error("fsp_flash_dev: unsupported parameter value");
	end

	// ==========================================================
	// helpers
	function automatic logic [3:0] first_set(input logic [SECS-1:0] v);
		first_set = 4'h0;
		for (int i = SECS - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 4'(i);
			end
		end
	endfunction

	function automatic int unsigned bit_at(input logic [3:0] s, input logic [AW-1:0] o);
		return (int'(s) * DEPTH + int'(o)) * 8;
	endfunction

	fsp_dev_q_t q_ff;
	fsp_dev_q_t nxt_q;
	logic [SECS-1:0] sel;
	logic [SECS-1:0] prot;
	logic [3:0] sidx;
	logic [AW-1:0] boff;
	logic [7:0] old_p;
	logic wr;
	logic rd;
	logic hit1;
	logic hit2;
	logic busy;

	assign sel = {bus.boot_sector_select, bus.main_sector_select};
	assign prot = {prot_boot, prot_main};
	assign sidx = first_set(sel);
	assign boff = bus.addr[AW-1:0];
	assign old_p = q_ff.mem[bit_at(q_ff.psec, q_ff.paddr) +: 8];
	// array accesses without a sector select are not for this flash
	assign wr = bus.wr_strobe && |sel && !bus.io_select;
	assign rd = bus.rd_strobe && |sel && !bus.io_select;
	assign hit1 = bus.addr == fsp_pkg::UNLOCK1_ADDR && bus.wdata == fsp_pkg::UNLOCK1_DATA;
	assign hit2 = bus.addr == fsp_pkg::UNLOCK2_ADDR && bus.wdata == fsp_pkg::UNLOCK2_DATA;
	assign busy = q_ff.st inside {S_PROG_BUSY, S_ERASE_BUSY, S_BLANK};

	assign bus.rdata = q_ff.rdata;
	assign bus.flash_ready = q_ff.ready;

	// ==========================================================
	// next state
	always_comb begin
		logic go_erase;
		logic [7:0] stat;
		nxt_q = q_ff;
		go_erase = 1'b0;
		stat = 8'h00;
		// bits 4, 2, 1, 0 carry no meaning and read as zero
		stat[fsp_pkg::DATA_POLL_POS] = q_ff.is_prog && !q_ff.pdata[7]; // [RULE4] [RULE5] [RULE7]
		stat[fsp_pkg::TOGGLE_POS] = q_ff.toggle; // [RULE4]
		stat[fsp_pkg::ERROR_POS] = q_ff.error; // [RULE4]
		stat[fsp_pkg::WINDOW_POS] = q_ff.st != S_WINDOW; // [RULE4] [RULE13]

		if (busy) begin
			// writes are ignored while an algorithm runs
			if (q_ff.timer != '0) begin
				nxt_q.timer = q_ff.timer - fsp_pkg::TW'(1);
			end else begin
				nxt_q.st = S_READ;
				nxt_q.ready = 1'b1; // [RULE24]
				nxt_q.erase_mask = '0;
				if (q_ff.st != S_BLANK) begin
					if (force_fail || (q_ff.st == S_PROG_BUSY && (old_p & q_ff.pdata) != q_ff.pdata)) begin
						nxt_q.st = S_ERROR; // [RULE11]
						nxt_q.error = 1'b1; // [RULE11]
					end else if (q_ff.st == S_PROG_BUSY) begin
						nxt_q.mem[bit_at(q_ff.psec, q_ff.paddr) +: 8] = q_ff.pdata; // [RULE14]
					end else begin
						for (int s = 0; s < SECS; s++) begin
							if (q_ff.erase_mask[s] && !prot[s]) begin
								nxt_q.mem[s*DEPTH*8 +: DEPTH*8] = '1; // [RULE14]
							end
						end
					end
				end
			end
		end else if (wr) begin
			if (bus.wdata == fsp_pkg::CMD_RESET) begin
				nxt_q.st = S_READ; // [RULE23]
				nxt_q.error = 1'b0; // [RULE12]
				nxt_q.erase_mask = '0;
				nxt_q.ready = 1'b1;
			end else begin
				unique case (q_ff.st)
					S_READ: begin
						nxt_q.st = hit1 ? S_UNL1 : S_READ; // [RULE22]
					end
					S_UNL1: begin
						nxt_q.st = hit2 ? S_UNL2 : S_READ; // [RULE22]
					end
					S_UNL2: begin
						nxt_q.st = S_READ;
						if (bus.addr == fsp_pkg::UNLOCK1_ADDR) begin
							if (bus.wdata == fsp_pkg::CMD_PROGRAM) begin
								nxt_q.st = S_PROG_DATA;
							end else if (bus.wdata == fsp_pkg::CMD_ERASE_SETUP) begin
								nxt_q.st = S_ER_UNL0;
							end else if (bus.wdata == fsp_pkg::CMD_PROT_READ) begin
								nxt_q.st = S_PROT; // [RULE1] [RULE22]
							end
						end
					end
					S_PROG_DATA: begin
						nxt_q.st = S_READ;
						if (!prot[sidx]) begin // [RULE8]
							nxt_q.st = S_PROG_BUSY; // [RULE6]
							nxt_q.timer = PROG_T;
							nxt_q.psec = sidx;
							nxt_q.paddr = boff;
							nxt_q.pdata = bus.wdata;
							nxt_q.is_prog = 1'b1;
							nxt_q.ready = 1'b0; // [RULE24]
						end
					end
					S_ER_UNL0: begin
						nxt_q.st = hit1 ? S_ER_UNL1 : S_READ;
					end
					S_ER_UNL1: begin
						nxt_q.st = hit2 ? S_ER_UNL2 : S_READ;
					end
					S_ER_UNL2, S_WINDOW: begin
						// anything but a sector erase, or a bulk erase at 555 before the window, aborts to array reads
						nxt_q.st = S_READ;
						nxt_q.ready = 1'b1;
						nxt_q.erase_mask = '0;
						nxt_q.is_prog = 1'b0;
						if (bus.wdata == fsp_pkg::CMD_SECTOR_ERASE) begin
							nxt_q.st = S_WINDOW; // [RULE6]
							nxt_q.erase_mask = q_ff.erase_mask | (SECS'(1) << sidx);
							nxt_q.timer = WINDOW_T; // [RULE13]
							nxt_q.ready = 1'b0; // [RULE24]
						end else if (bus.wdata == fsp_pkg::CMD_BULK_ERASE && q_ff.st == S_ER_UNL2 &&
							bus.addr == fsp_pkg::UNLOCK1_ADDR) begin
							nxt_q.erase_mask = '1;
							go_erase = 1'b1;
						end
					end
					S_PROT, S_ERROR: begin
						nxt_q.st = q_ff.st; // [RULE23]
					end
					default: begin
						nxt_q.st = S_READ;
					end
				endcase
			end
		end else if (q_ff.st == S_WINDOW) begin
			if (q_ff.timer != '0) begin
				nxt_q.timer = q_ff.timer - fsp_pkg::TW'(1);
			end else begin
				go_erase = 1'b1; // [RULE13]
			end
		end

		if (go_erase) begin
			nxt_q.ready = 1'b0; // [RULE24]
			if ((nxt_q.erase_mask & ~prot) == '0) begin
				nxt_q.st = S_BLANK; // [RULE9]
				nxt_q.timer = BLANK_T; // [RULE9]
			end else begin
				nxt_q.st = S_ERASE_BUSY;
				nxt_q.timer = ERASE_T;
			end
		end

		// reads
		if (rd) begin
			if (busy || q_ff.st == S_WINDOW || q_ff.st == S_ERROR) begin
				nxt_q.rdata = stat; // [RULE3] [RULE18]
				nxt_q.toggle = !q_ff.toggle; // [RULE10]
			end else if (q_ff.st == S_PROT) begin
				nxt_q.rdata = ((bus.addr & fsp_pkg::PROT_ADDR_MASK) == fsp_pkg::PROT_ADDR_MATCH &&
					prot[sidx]) ? fsp_pkg::PROT_YES : fsp_pkg::PROT_NO; // [RULE1] [RULE2]
			end else begin
				nxt_q.rdata = q_ff.mem[bit_at(sidx, boff) +: 8]; // [RULE5] [RULE7]
			end
		end else if (bus.rd_strobe && bus.io_select) begin
			if (bus.addr == fsp_pkg::IO_MAIN_PROT) begin
				nxt_q.rdata = 8'(prot_main); // [RULE21]
			end else if (bus.addr == fsp_pkg::IO_BOOT_PROT) begin
				nxt_q.rdata = 8'(prot_boot); // [RULE21]
			end else begin
				nxt_q.rdata = 8'h00;
			end
		end
	end

	// ==========================================================
	// state register; the array powers up erased
	always_ff @(posedge clk) begin
		if (reset) begin
			q_ff <= '0;
			q_ff.ready <= 1'b1;
			q_ff.mem <= '1;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule
`default_nettype wire

/* File: hw/fsp_flash_host.sv */
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_host (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// flash bus
	fsp_bus_if.mcu bus
);
	// ==========================================================
	// types
	typedef enum logic [1:0] {H_IDLE, H_WR, H_RD, H_RCAP} fsp_host_st_t;

	typedef struct packed {
		fsp_host_st_t st;
		logic [2:0] op;
		logic [2:0] step;
		logic [3:0] sec;
		logic [11:0] paddr;
		logic [7:0] pdata;
		logic [7:0] prev;
		logic have_prev;
		logic recheck;
		logic verify;
		logic fail;
		logic [7:0] result;
		logic [11:0] bad;
		logic avs_wait;
		logic [31:0] avs_rdata;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic io;
		logic [11:0] sel;
	} fsp_host_q_t;

	// ==========================================================
	// instruction tables
	function automatic logic [2:0] n_writes(input logic [2:0] op);
		unique case (op)
			fsp_pkg::OP_PROGRAM: n_writes = 3'h4;
			fsp_pkg::OP_SECTOR_ERASE, fsp_pkg::OP_BULK_ERASE: n_writes = 3'h6;
			fsp_pkg::OP_PROT_READ: n_writes = 3'h3;
			fsp_pkg::OP_RESET: n_writes = 3'h1;
			default: n_writes = 3'h0;
		endcase
	endfunction

	function automatic logic [19:0] wr_cmd(input logic [2:0] op, input logic [2:0] step,
		input logic [11:0] a, input logic [7:0] d);
		wr_cmd = {fsp_pkg::UNLOCK1_ADDR, fsp_pkg::UNLOCK1_DATA};
		if (op == fsp_pkg::OP_RESET) begin
			wr_cmd = {fsp_pkg::UNLOCK1_ADDR, fsp_pkg::CMD_RESET};
		end else begin
			case (step)
				3'h1, 3'h4: wr_cmd = {fsp_pkg::UNLOCK2_ADDR, fsp_pkg::UNLOCK2_DATA};
				3'h2: wr_cmd = {fsp_pkg::UNLOCK1_ADDR, op == fsp_pkg::OP_PROGRAM ? fsp_pkg::CMD_PROGRAM :
					op == fsp_pkg::OP_PROT_READ ? fsp_pkg::CMD_PROT_READ : fsp_pkg::CMD_ERASE_SETUP};
				3'h3: wr_cmd = op == fsp_pkg::OP_PROGRAM ? {a, d} :
					{fsp_pkg::UNLOCK1_ADDR, fsp_pkg::UNLOCK1_DATA};
				3'h5: wr_cmd = op == fsp_pkg::OP_BULK_ERASE ?
					{fsp_pkg::UNLOCK1_ADDR, fsp_pkg::CMD_BULK_ERASE} : {a, fsp_pkg::CMD_SECTOR_ERASE};
				default: wr_cmd = {fsp_pkg::UNLOCK1_ADDR, fsp_pkg::UNLOCK1_DATA};
			endcase
		end
	endfunction

	fsp_host_q_t q_ff;
	fsp_host_q_t nxt_q;
	logic busy;

	assign busy = q_ff.st != H_IDLE;
	assign avs_readdata = q_ff.avs_rdata;
	assign avs_waitrequest = q_ff.avs_wait;
	assign bus.addr = q_ff.addr;
	assign bus.wdata = q_ff.wdata;
	assign bus.wr_strobe = q_ff.wr;
	assign bus.rd_strobe = q_ff.rd;
	assign bus.io_select = q_ff.io;
	assign bus.main_sector_select = q_ff.sel[fsp_pkg::N_MAIN-1:0];
	assign bus.boot_sector_select = q_ff.sel[11:fsp_pkg::N_MAIN];

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0] rdv;
		logic done_now;
		nxt_q = q_ff;
		rdv = bus.rdata;
		done_now = 1'b0;
		nxt_q.wr = 1'b0;
		nxt_q.rd = 1'b0;
		nxt_q.avs_wait = 1'b1;

		// one wait cycle per access; a write takes effect when waitrequest is seen low
		if ((avs_read || avs_write) && q_ff.avs_wait) begin
			nxt_q.avs_wait = 1'b0;
			unique case (avs_address)
				fsp_pkg::REG_STATUS: nxt_q.avs_rdata = {4'h0, q_ff.bad, q_ff.result, 6'h00, q_ff.fail, busy};
				fsp_pkg::REG_ADDR: nxt_q.avs_rdata = {20'h00000, q_ff.paddr};
				fsp_pkg::REG_DATA: nxt_q.avs_rdata = {24'h000000, q_ff.pdata};
				fsp_pkg::REG_CTRL: nxt_q.avs_rdata = {24'h000000, q_ff.sec, 1'b0, q_ff.op};
				default: nxt_q.avs_rdata = 32'h00000000;
			endcase
		end
		if (avs_write && !q_ff.avs_wait && !busy) begin // [RULE15]
			if (avs_address == fsp_pkg::REG_ADDR) begin
				nxt_q.paddr = avs_writedata[11:0];
			end else if (avs_address == fsp_pkg::REG_DATA) begin
				nxt_q.pdata = avs_writedata[7:0];
			end else if (avs_address == fsp_pkg::REG_CTRL && avs_writedata[2:0] != 3'h0) begin
				nxt_q.fail = 1'b0;
				if (avs_writedata[7:4] > 4'hb || ((avs_writedata[2:0] == fsp_pkg::OP_PROGRAM ||
					avs_writedata[2:0] == fsp_pkg::OP_SECTOR_ERASE) && q_ff.bad[avs_writedata[7:4]])) begin
					nxt_q.fail = 1'b1; // [RULE20]
				end else begin
					nxt_q.op = avs_writedata[2:0];
					nxt_q.sec = avs_writedata[7:4];
					nxt_q.step = 3'h0;
					nxt_q.have_prev = 1'b0;
					nxt_q.recheck = 1'b0;
					nxt_q.verify = 1'b0;
					nxt_q.st = H_WR;
				end
			end
		end

		unique case (q_ff.st)
			H_IDLE: begin
				nxt_q.io = 1'b0;
			end
			H_WR: begin
				if (q_ff.step != n_writes(q_ff.op)) begin
					{nxt_q.addr, nxt_q.wdata} = wr_cmd(q_ff.op, q_ff.step, q_ff.paddr, q_ff.pdata); // [RULE22]
					nxt_q.wr = 1'b1;
					nxt_q.step = q_ff.step + 3'h1;
				end else if (q_ff.op == fsp_pkg::OP_RESET) begin
					nxt_q.st = H_IDLE;
				end else begin
					nxt_q.addr = q_ff.op == fsp_pkg::OP_PROT_READ ? fsp_pkg::PROT_ADDR_MATCH : q_ff.paddr; // [RULE1]
					nxt_q.io = q_ff.op == fsp_pkg::OP_IO_READ;
					nxt_q.rd = 1'b1;
					nxt_q.st = H_RD;
				end
			end
			H_RD: begin
				nxt_q.st = H_RCAP;
			end
			H_RCAP: begin
				nxt_q.st = H_IDLE;
				nxt_q.result = rdv;
				if (q_ff.op == fsp_pkg::OP_PROT_READ) begin
					nxt_q.op = fsp_pkg::OP_RESET; // [RULE23]
					nxt_q.step = 3'h0;
					nxt_q.st = H_WR;
				end else if (q_ff.op inside {fsp_pkg::OP_PROGRAM, fsp_pkg::OP_SECTOR_ERASE,
					fsp_pkg::OP_BULK_ERASE}) begin
					if (q_ff.op == fsp_pkg::OP_PROGRAM) begin
						done_now = rdv[7] == q_ff.pdata[7]; // [RULE16]
					end else begin
						done_now = q_ff.have_prev && rdv[6] == q_ff.prev[6]; // [RULE17]
					end
					nxt_q.prev = rdv;
					nxt_q.have_prev = 1'b1;
					if (q_ff.verify ? rdv != q_ff.pdata : (!done_now && q_ff.recheck)) begin
						nxt_q.fail = 1'b1;
						if (q_ff.op != fsp_pkg::OP_BULK_ERASE) begin
							nxt_q.bad[q_ff.sec] = 1'b1; // [RULE20]
						end
						nxt_q.op = fsp_pkg::OP_RESET; // [RULE23]
						nxt_q.step = 3'h0;
						nxt_q.st = H_WR;
					end else if (q_ff.verify) begin
						nxt_q.st = H_IDLE;
					end else if (done_now && q_ff.op == fsp_pkg::OP_PROGRAM) begin
						nxt_q.verify = 1'b1; // [RULE19]
						nxt_q.rd = 1'b1;
						nxt_q.st = H_RD;
					end else if (!done_now) begin
						// error bit seen: one more look before calling it a failure
						nxt_q.recheck = rdv[5]; // [RULE16] [RULE17]
						nxt_q.rd = 1'b1; // [RULE15]
						nxt_q.st = H_RD;
					end
				end
			end
		endcase
		nxt_q.sel = nxt_q.st == H_IDLE ? 12'h000 : 12'h001 << nxt_q.sec;
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			q_ff <= '0;
			q_ff.avs_wait <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule
`default_nettype wire

/* File: hw/fsp_pkg.sv */
package fsp_pkg;
	// ==========================================================
	// sector counts and timer width
	localparam int N_MAIN = 8;
	localparam int N_BOOT = 4;
	localparam int TW = 12;
	// ==========================================================
	// timing at the 20 MHz system clock
	localparam int CLK_PERIOD_NS = 50;
	localparam int WINDOW_NOM_US = 100;
	localparam int WINDOW_MARGIN_PCT = 20;
	localparam int WINDOW_CYC =
		(WINDOW_NOM_US * (100 + WINDOW_MARGIN_PCT) / 100) * 1000 / CLK_PERIOD_NS;
	localparam int BLANK_US = 100;
	localparam int BLANK_CYC = BLANK_US * 1000 / CLK_PERIOD_NS;
	// ==========================================================
	// instruction coding
	localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
	localparam logic [11:0] UNLOCK2_ADDR = 12'haaa;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
	localparam logic [7:0] CMD_PROT_READ = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	// protection read: a6, a1, a0 must be 0, 1, 0
	localparam logic [11:0] PROT_ADDR_MASK = 12'h043;
	localparam logic [11:0] PROT_ADDR_MATCH = 12'h002;
	localparam logic [7:0] PROT_YES = 8'h01;
	localparam logic [7:0] PROT_NO = 8'h00;
	// ==========================================================
	// status byte layout
	localparam int DATA_POLL_POS = 7;
	localparam int TOGGLE_POS = 6;
	localparam int ERROR_POS = 5;
	localparam int WINDOW_POS = 3;
	// ==========================================================
	// protection registers in i/o space
	localparam logic [11:0] IO_MAIN_PROT = 12'h0c0;
	localparam logic [11:0] IO_BOOT_PROT = 12'h0c2;
	// ==========================================================
	// controller registers on avalon-mm
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
	localparam logic [2:0] OP_BULK_ERASE = 3'h3;
	localparam logic [2:0] OP_PROT_READ = 3'h4;
	localparam logic [2:0] OP_READ = 3'h5;
	localparam logic [2:0] OP_RESET = 3'h6;
	localparam logic [2:0] OP_IO_READ = 3'h7;
endpackage

/* File: testbench/fsp_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module fsp_monitor #(
	parameter int ERASE_CYC = 400
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// flash link
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic io_select,
	input wire logic [fsp_pkg::N_MAIN-1:0] main_sector_select,
	input wire logic [fsp_pkg::N_BOOT-1:0] boot_sector_select,
	input wire logic flash_ready
);
	// ====
	// helper state
	logic sel, wr, rdv_ff, have_ff, tog_ff, erase_ff, pnext_ff, pbit_ff, prot_ff;
	logic [11:0] win_ff, busy_ff;
	assign sel = |{main_sector_select, boot_sector_select};
	assign wr = wr_strobe && sel && !io_select;
	always_ff @(posedge clk) begin
		rdv_ff <= rd_strobe && sel && !io_select && !reset;
		tog_ff <= rdv_ff ? rdata[6] : tog_ff;
		have_ff <= !reset && !flash_ready && (have_ff || rdv_ff);
		busy_ff <= (reset || flash_ready) ? 12'h000 : busy_ff + 12'(busy_ff != 12'hfff);
		pnext_ff <= wr && !pnext_ff && wdata == fsp_pkg::CMD_PROGRAM;
		pbit_ff <= (wr && pnext_ff) ? wdata[7] : pbit_ff;
		if (reset) begin
			erase_ff <= 1'b0;
			prot_ff <= 1'b0;
			win_ff <= 12'hfff;
		end else if (wr && !pnext_ff) begin
			erase_ff <= (erase_ff || wdata == fsp_pkg::CMD_ERASE_SETUP) && wdata != 8'ha0;
			prot_ff <= (prot_ff || wdata == fsp_pkg::CMD_PROT_READ) && wdata != 8'hf0;
			win_ff <= (erase_ff && wdata == fsp_pkg::CMD_SECTOR_ERASE) ? 12'h000 : win_ff;
		end else begin
			win_ff <= win_ff + 12'(win_ff != 12'hfff);
		end
	end
	// ====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_busy_read;
		rdv_ff && !flash_ready;
	endsequence
	a_reset_idle_out: assert property ($fell(reset) |-> flash_ready && rdata == 8'h00)
		else $error("link outputs not idle after reset");
	a_toggle_flips: assert property (s_busy_read |-> !have_ff || rdata[6] != tog_ff)
		else $error("toggle bit held");
	a_poll_bit_value: assert property (s_busy_read |-> rdata[7] == (!erase_ff && !pbit_ff))
		else $error("poll bit wrong");
	a_error_stays_low: assert property (s_busy_read |-> !rdata[5])
		else $error("error bit while busy");
	a_window_bit_low: assert property (s_busy_read ##0 win_ff < 12'd2300 |-> !rdata[3])
		else $error("window bit high in window");
	a_window_bit_high: assert property (s_busy_read ##0 win_ff > 12'd2500 |-> rdata[3])
		else $error("window bit low after window");
	a_prot_read_byte: assert property (rdv_ff && prot_ff |-> rdata[7:1] == 7'h00)
		else $error("protection byte not 00 or 01");
	a_erase_goes_busy: assert property (erase_ff && wr && (wdata == 8'h30 || wdata == 8'h10)
		|=> !flash_ready [*2])
		else $error("erase did not go busy");
	a_busy_bounded: assert property (busy_ff < 12'd2420 + 12'(ERASE_CYC))
		else $error("busy too long");
endmodule
`default_nettype wire

/* File: testbench/test_flash_status_and_protect_read.sv */
`timescale 1ns/100ps
`default_nettype none
module test_flash_status_and_protect_read;
	// ====
	// design and stimulus
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, st;
	logic wreq;
	logic [fsp_pkg::N_MAIN-1:0] prot_main = 8'h00;
	logic [fsp_pkg::N_BOOT-1:0] prot_boot = 4'h0;
	logic force_fail = 1'b0;
	int bad_count = 0;
	int checks = 0;
	int low_cnt = 0;
	fsp_bus_if bus();
	always #25 clk = !clk;
	always @(posedge clk) if (bus.flash_ready === 1'b0) low_cnt <= low_cnt + 1;
	fsp_flash_dev #(.DEPTH(4), .PROG_CYC(4), .ERASE_CYC(8)) fsp_flash_dev_inst (.clk(clk),
		.reset(reset), .bus(bus), .prot_main(prot_main), .prot_boot(prot_boot),
		.force_fail(force_fail));
	fsp_flash_host fsp_flash_host_inst (.clk(clk), .reset(reset), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .bus(bus));
	fsp_monitor #(.ERASE_CYC(8)) fsp_monitor_inst (.clk(clk), .reset(reset), .addr(bus.addr),
		.wdata(bus.wdata), .rdata(bus.rdata), .wr_strobe(bus.wr_strobe),
		.rd_strobe(bus.rd_strobe), .io_select(bus.io_select),
		.main_sector_select(bus.main_sector_select),
		.boot_sector_select(bus.boot_sector_select), .flash_ready(bus.flash_ready));
	// ====
	// shared tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			check(8'h01, 8'h00);
			report_and_stop();
		end
	endtask
	// waitrequest is sampled at the rising edge; the request stands until that edge sees it low
	task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		bound(n, 50);
		st = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic run(input logic [2:0] op, input logic [3:0] sec, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		av(fsp_pkg::REG_ADDR, 1'b1, {20'h0, a});
		av(fsp_pkg::REG_DATA, 1'b1, {24'h0, d});
		av(fsp_pkg::REG_CTRL, 1'b1, {24'h0, sec, 1'b0, op});
		n = 0;
		do begin
			av(fsp_pkg::REG_STATUS, 1'b0, 32'h0);
			n++;
		end while (st[0] !== 1'b0 && n < 2000);
		bound(n, 2000);
	endtask
	// ====
	// scenarios
	task automatic t_erase();
		check(8'(bus.flash_ready), 8'h01);
		av(4'h1, 1'b0, 32'h0);
		check(8'(|st), 8'h00);
		run(fsp_pkg::OP_PROGRAM, 4'd4, 12'h002, 8'h3c);
		run(fsp_pkg::OP_SECTOR_ERASE, 4'd4, 12'h000, 8'h00);
		check(8'(st[1]), 8'h00);
		run(fsp_pkg::OP_READ, 4'd4, 12'h002, 8'h00);
		check(st[15:8], 8'hff);
		force_fail <= 1'b1;
		run(fsp_pkg::OP_SECTOR_ERASE, 4'd5, 12'h000, 8'h00);
		force_fail <= 1'b0;
		check(8'({st[21], st[1]}), 8'h03);
		$display("erase test done");
	endtask
	task automatic t_program();
		run(fsp_pkg::OP_PROGRAM, 4'd1, 12'h001, 8'h5a);
		run(fsp_pkg::OP_READ, 4'd1, 12'h001, 8'h00);
		check(st[15:8], 8'h5a);
		// setting cleared bits back to one must fail
		run(fsp_pkg::OP_PROGRAM, 4'd1, 12'h001, 8'hff);
		check(8'({st[17], st[1]}), 8'h03);
		run(fsp_pkg::OP_READ, 4'd1, 12'h001, 8'h00);
		check(st[15:8], 8'h5a);
		// a failed sector is refused before any flash write
		run(fsp_pkg::OP_PROGRAM, 4'd1, 12'h002, 8'h00);
		check(8'({st[17], st[1]}), 8'h03);
		run(fsp_pkg::OP_READ, 4'd1, 12'h002, 8'h00);
		check(st[15:8], 8'hff);
		run(fsp_pkg::OP_RESET, 4'd1, 12'h000, 8'h00);
		check(8'(st[1]), 8'h00);
		$display("program test done");
	endtask
	task automatic t_protect();
		prot_main <= 8'h04;
		prot_boot <= 4'h2;
		run(fsp_pkg::OP_PROT_READ, 4'd2, 12'h002, 8'h00);
		check(st[15:8], fsp_pkg::PROT_YES);
		run(fsp_pkg::OP_PROT_READ, 4'd3, 12'h002, 8'h00);
		check(st[15:8], fsp_pkg::PROT_NO);
		run(fsp_pkg::OP_PROT_READ, 4'd9, 12'h002, 8'h00);
		check(st[15:8], fsp_pkg::PROT_YES);
		run(fsp_pkg::OP_IO_READ, 4'd0, fsp_pkg::IO_MAIN_PROT, 8'h00);
		check(st[15:8], 8'h04);
		run(fsp_pkg::OP_IO_READ, 4'd0, fsp_pkg::IO_BOOT_PROT, 8'h00);
		check(st[15:8], 8'h02);
		run(fsp_pkg::OP_PROGRAM, 4'd2, 12'h000, 8'h80);
		run(fsp_pkg::OP_READ, 4'd2, 12'h000, 8'h00);
		check(st[15:8], 8'hff);
		$display("protect test done");
	endtask
	task automatic t_blank();
		int lc;
		run(fsp_pkg::OP_PROGRAM, 4'd3, 12'h000, 8'h12);
		prot_main <= 8'hff;
		prot_boot <= 4'hf;
		lc = low_cnt;
		run(fsp_pkg::OP_BULK_ERASE, 4'd0, 12'h000, 8'h00);
		lc = low_cnt - lc;
		check(8'(lc >= fsp_pkg::BLANK_CYC && lc < fsp_pkg::BLANK_CYC + 40), 8'h01);
		run(fsp_pkg::OP_READ, 4'd3, 12'h000, 8'h00);
		check(st[15:8], 8'h12);
		$display("blank test done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_erase();
		t_program();
		t_protect();
		t_blank();
		report_and_stop();
	end
endmodule
`default_nettype wire
